// ---- hw/stc_baud_tick.sv ----
`timescale 1ns/100ps
// Baud tick generator: one tick every divisor+1 system clocks at high speed, four times the divisor plus one at low speed.
module stc_baud_tick (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        run,
   input  wire logic [15:0] divisor,
   input  wire logic        high_speed,
   output logic             tick
);
   import stc_pkg::*;
   logic [17:0] count;
   logic [17:0] limit;

   // Low-speed range counts to a limit four times that of the high-speed range.
   always_comb begin
      limit = high_speed ? {2'b00, divisor} : {divisor, 2'b00};
   end

   // Counter restarts whenever the shifter is idle so the first bit is full length.
   always_ff @(posedge clk) begin
      if (reset || !run) begin
         count <= 18'h00000;
         tick  <= 1'b0;
      end else if (count >= limit) begin
         count <= 18'h00000;
         tick  <= 1'b1;
      end else begin
         count <= count + 18'h00001;
         tick  <= 1'b0;
      end
   end
endmodule

// ---- hw/stc_serial_tx.sv ----
`timescale 1ns/100ps
// Transmit status and control block of the serial port with an AXI4-Lite slave.
module stc_serial_tx (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [13:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [13:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        clock_pin_in,
   output logic             transmit_pin_out,
   output logic             transmit_pin_oe,
   output logic             clock_pin_out,
   output logic             clock_pin_oe
);
   import stc_pkg::*;

   logic [7:0]  tx_ctrl;
   logic [7:0]  rx_ctrl;
   logic [7:0]  baud_ctrl;
   logic [15:0] divisor;
   logic [8:0]  shift_data;
   logic [3:0]  bit_count;
   logic        data_pending;
   logic [8:0]  pending_data;
   stc_state_e  state;
   logic        baud_tick;
   logic        clk_in_d;
   logic        aw_held;
   logic [11:0] aw_addr;
   logic        w_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        do_write;
   logic        data_write;
   logic        sync_mode;
   logic        tx_active;
   logic        slave_edge;
   logic        bit_step;

   // Shared address match used by both bus paths.
   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == OFF_TX_CONTROL_STATUS) || (a == OFF_TX_DATA) ||
                  (a == OFF_RX_CONTROL_STATUS) || (a == OFF_BAUD_CONTROL) ||
                  (a == OFF_BAUD_DIV_HIGH) || (a == OFF_BAUD_DIV_LOW);
   endfunction

   assign sync_mode  = tx_ctrl[BIT_SYNC_MODE];
   // Receive enables take the port away from the transmitter in sync mode.
   assign tx_active  = tx_ctrl[BIT_TX_ENABLE] &&
                       !(sync_mode && (rx_ctrl[BIT_SINGLE_RX] || rx_ctrl[BIT_CONTINUOUS_RX]));
   assign slave_edge = clock_pin_in && !clk_in_d;
   // Master and async paths step on the baud tick; slave steps on the external clock edge.
   assign bit_step   = (sync_mode && !tx_ctrl[BIT_CLOCK_SOURCE]) ? slave_edge : baud_tick;
   assign do_write   = aw_held && w_held && !s_axi_bvalid;
   assign data_write = do_write && (aw_addr == OFF_TX_DATA) && w_strb[0];

   stc_baud_tick u_baud (
      .clk        (clk),
      .reset      (reset),
      .run        (state != STC_IDLE),
      .divisor    (divisor),
      .high_speed (tx_ctrl[BIT_HIGH_SPEED] && !sync_mode),
      .tick       (baud_tick)
   );

   // Write address and data are caught independently, in either order.
   always_ff @(posedge clk) begin
      if (reset) begin
         aw_held <= 1'b0;
         aw_addr <= 12'h000;
         w_held  <= 1'b0;
         w_data  <= 32'h00000000;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr[13:2];
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // Ready is high only while the holding slot for that channel is free.
   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      end
   end

   // Write response follows once both halves are present.
   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control registers; the empty bit and break clear are owned by hardware.
   always_ff @(posedge clk) begin
      if (reset) begin
         tx_ctrl   <= RST_TX_CONTROL;
         rx_ctrl   <= RST_ZERO;
         baud_ctrl <= RST_ZERO;
         divisor   <= RST_DIVISOR;
      end else begin
         if (do_write && w_strb[0]) begin
            case (aw_addr)
               OFF_TX_CONTROL_STATUS: begin
                  tx_ctrl[7:2] <= w_data[7:2];
                  tx_ctrl[BIT_NINTH_DATA] <= w_data[BIT_NINTH_DATA];
               end
               OFF_RX_CONTROL_STATUS: rx_ctrl <= w_data[7:0];
               OFF_BAUD_CONTROL:      baud_ctrl <= w_data[7:0];
               OFF_BAUD_DIV_HIGH:     divisor[15:8] <= w_data[7:0];
               OFF_BAUD_DIV_LOW:      divisor[7:0] <= w_data[7:0];
               default:               divisor <= divisor;
            endcase
         end
         // Hardware clear on break completion wins over a same-cycle write.
         if (state == STC_BREAK && bit_step && bit_count == 4'h0) begin
            tx_ctrl[BIT_BREAK] <= 1'b0;
         end
         tx_ctrl[BIT_SR_EMPTY] <= (state == STC_IDLE) && !data_pending;
      end
   end

   // One-word holding slot; a write while full overwrites the waiting word.
   always_ff @(posedge clk) begin
      if (reset) begin
         data_pending <= 1'b0;
         pending_data <= 9'h000;
      end else if (data_write) begin
         data_pending <= 1'b1;
         pending_data <= {tx_ctrl[BIT_NINTH_DATA], w_data[7:0]};
      end else if (state == STC_IDLE && tx_active) begin
         data_pending <= 1'b0;
      end
   end

   // External clock history for slave edge detection; inputs are synchronous.
   always_ff @(posedge clk) begin
      if (reset) begin
         clk_in_d <= 1'b0;
      end else begin
         clk_in_d <= clock_pin_in;
      end
   end

   // Shifter: async frames carry start and stop, sync frames carry data only.
   always_ff @(posedge clk) begin
      if (reset) begin
         state            <= STC_IDLE;
         shift_data       <= 9'h1ff;
         bit_count        <= 4'h0;
         transmit_pin_out <= 1'b1;
      end else begin
         case (state)
            STC_IDLE: begin
               transmit_pin_out <= 1'b1;
               if (tx_active && data_pending) begin
                  if (!sync_mode && tx_ctrl[BIT_BREAK]) begin
                     state            <= STC_BREAK;
                     transmit_pin_out <= 1'b0;
                     bit_count        <= BREAK_LOW_BITS - 4'h1;
                  end else if (!sync_mode) begin
                     state            <= STC_SHIFT;
                     transmit_pin_out <= 1'b0;
                     // An 8-bit frame puts a one above the data, which becomes the stop bit.
                     shift_data       <= tx_ctrl[BIT_NINE_SELECT] ? pending_data :
                                         {1'b1, pending_data[7:0]};
                     bit_count        <= tx_ctrl[BIT_NINE_SELECT] ? 4'ha : 4'h9;
                  end else begin
                     state            <= STC_SHIFT;
                     transmit_pin_out <= pending_data[0];
                     shift_data       <= {1'b1, pending_data[8:1]};
                     bit_count        <= tx_ctrl[BIT_NINE_SELECT] ? 4'h8 : 4'h7;
                  end
               end
            end
            STC_SHIFT: begin
               if (!tx_active) begin
                  state            <= STC_IDLE;
                  transmit_pin_out <= 1'b1;
               end else if (bit_step) begin
                  if (bit_count == 4'h0) begin
                     state            <= STC_IDLE;
                     transmit_pin_out <= 1'b1;
                  end else begin
                     // Sent LSB first; the ones shifted in at the top form the stop bit of a 9-bit frame.
                     transmit_pin_out <= shift_data[0];
                     shift_data       <= {1'b1, shift_data[8:1]};
                     bit_count        <= bit_count - 4'h1;
                  end
               end
            end
            STC_BREAK: begin
               if (bit_step) begin
                  if (bit_count == 4'h0) begin
                     state            <= STC_IDLE;
                     transmit_pin_out <= 1'b1;
                  end else begin
                     bit_count <= bit_count - 4'h1;
                  end
               end
            end
            default: state <= STC_IDLE;
         endcase
      end
   end

   // Pin directions and the master serial clock.
   always_ff @(posedge clk) begin
      if (reset) begin
         transmit_pin_oe <= 1'b0;
         clock_pin_oe    <= 1'b0;
         clock_pin_out   <= 1'b0;
      end else begin
         transmit_pin_oe <= tx_active;
         clock_pin_oe    <= sync_mode && tx_ctrl[BIT_CLOCK_SOURCE];
         // Clock falls as each bit is launched and rises a cycle later, so the far side
         // gets settled data on every rising edge; the price is a short low phase.
         clock_pin_out   <= sync_mode && tx_ctrl[BIT_CLOCK_SOURCE] && state == STC_SHIFT &&
                            !bit_step;
      end
   end

   // Read channel: one read at a time, answered in the cycle after the address is taken.
   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= is_mapped(s_axi_araddr[13:2]) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr[13:2])
               OFF_TX_CONTROL_STATUS: s_axi_rdata <= {24'h000000, tx_ctrl};
               OFF_RX_CONTROL_STATUS: s_axi_rdata <= {24'h000000, rx_ctrl};
               OFF_BAUD_CONTROL:      s_axi_rdata <= {24'h000000, baud_ctrl};
               OFF_BAUD_DIV_HIGH:     s_axi_rdata <= {24'h000000, divisor[15:8]};
               OFF_BAUD_DIV_LOW:      s_axi_rdata <= {24'h000000, divisor[7:0]};
               default:               s_axi_rdata <= 32'h00000000;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Break must finish on the same step that clears its request bit.
   a_break_clear: assert property (@(posedge clk) disable iff (reset)
      (state == STC_BREAK && bit_step && bit_count == 4'h0) |=>
         (!tx_ctrl[BIT_BREAK] && state == STC_IDLE && transmit_pin_out))
      else $error("break bit not cleared at break end");
   // Empty flag tracks the shifter one cycle later.
   a_empty_flag: assert property (@(posedge clk) disable iff (reset)
      (state != STC_IDLE) |=> !tx_ctrl[BIT_SR_EMPTY])
      else $error("empty flag set while shifting");
   a_idle_high: assert property (@(posedge clk) disable iff (reset)
      (state == STC_IDLE && $past(state) == STC_IDLE) |-> transmit_pin_out)
      else $error("line not idle high");
   a_start_low: assert property (@(posedge clk) disable iff (reset)
      ($past(state) == STC_IDLE && state == STC_SHIFT && !sync_mode) |-> !transmit_pin_out)
      else $error("async frame missing low start");
   a_rx_override: assert property (@(posedge clk) disable iff (reset)
      (sync_mode && rx_ctrl[BIT_CONTINUOUS_RX]) |=> !transmit_pin_oe)
      else $error("transmitter active while receive enabled");
   a_tx_enable: assert property (@(posedge clk) disable iff (reset)
      (state == STC_SHIFT && !tx_active) |=> state == STC_IDLE)
      else $error("shifter kept running after disable");
   a_clock_master: assert property (@(posedge clk) disable iff (reset)
      clock_pin_oe |-> $past(sync_mode && tx_ctrl[BIT_CLOCK_SOURCE]))
      else $error("clock driven outside sync master");
   a_nine_bits: assert property (@(posedge clk) disable iff (reset)
      ($past(state) == STC_IDLE && state == STC_SHIFT && !sync_mode) |->
         bit_count == ($past(tx_ctrl[BIT_NINE_SELECT]) ? 4'ha : 4'h9))
      else $error("wrong frame length");
   a_reset_value: assert property (@(posedge clk)
      reset |=> tx_ctrl == RST_TX_CONTROL)
      else $error("transmit control word wrong after reset");
endmodule

// ---- include/stc_pkg.sv ----
// Package with register map, field positions, reset values and timing constants.
package stc_pkg;
   // Register indices; the byte address on the AXI4-Lite bus is four times the index.
   localparam logic [11:0] OFF_TX_CONTROL_STATUS = 12'hfad;
   localparam logic [11:0] OFF_TX_DATA           = 12'hfb0;
   localparam logic [11:0] OFF_RX_CONTROL_STATUS = 12'hfb4;
   localparam logic [11:0] OFF_BAUD_CONTROL      = 12'hfb8;
   localparam logic [11:0] OFF_BAUD_DIV_HIGH     = 12'hfbc;
   localparam logic [11:0] OFF_BAUD_DIV_LOW      = 12'hfc0;
   // Field positions in the transmit control word.
   localparam int BIT_CLOCK_SOURCE = 7;
   localparam int BIT_NINE_SELECT  = 6;
   localparam int BIT_TX_ENABLE    = 5;
   localparam int BIT_SYNC_MODE    = 4;
   localparam int BIT_BREAK        = 3;
   localparam int BIT_HIGH_SPEED   = 2;
   localparam int BIT_SR_EMPTY     = 1;
   localparam int BIT_NINTH_DATA   = 0;
   // Field positions in the receive control word.
   localparam int BIT_SINGLE_RX     = 5;
   localparam int BIT_CONTINUOUS_RX = 4;
   // Reset values.
   localparam logic [7:0] RST_TX_CONTROL = 8'h02;
   localparam logic [7:0] RST_ZERO       = 8'h00;
   localparam logic [15:0] RST_DIVISOR   = 16'h0004;
   // Break is one low start, twelve low bits, then a high stop.
   localparam logic [3:0] BREAK_LOW_BITS = 4'hd;
   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      STC_IDLE  = 2'b00,
      STC_SHIFT = 2'b01,
      STC_BREAK = 2'b10
   } stc_state_e;
endpackage

// ---- sim/serial_transmit_control_bench.sv ----
// Self-checking bench for the serial transmit control block.
`timescale 1ns/100ps
module serial_transmit_control_bench;
   import stc_pkg::*;
   logic clk = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, ck_in = 1'b0, nine = 1'b0;
   logic [13:0] awaddr = 14'h0000, araddr = 14'h0000;
   logic [31:0] wdata = 32'h0, seed = 32'h758d, d;
   logic [3:0]  wstrb = 4'h0;
   logic [7:0]  blen = 8'h05, c;
   logic [1:0]  r, bresp, rresp;
   logic [31:0] rdata;
   logic        awready, wready, bvalid, arready, rvalid, tx_out, tx_oe, ck_out, ck_oe;
   logic [8:0]  rx_data, sdata;
   logic        rx_err;
   logic [15:0] frames, f0;
   int          n_errors = 0, n_compared = 0, n;
   // The shared pin has a pull-up, so an undriven line reads idle high.
   wire line = tx_oe ? tx_out : 1'b1;

   stc_serial_tx uut (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .clock_pin_in(ck_in), .transmit_pin_out(tx_out),
      .transmit_pin_oe(tx_oe), .clock_pin_out(ck_out), .clock_pin_oe(ck_oe));
   stc_remote_rx far (.clk(clk), .line(line), .nine(nine), .bit_len(blen),
      .sck(ck_oe ? ck_out : ck_in), .data(rx_data), .frame_err(rx_err), .frames(frames),
      .sync_data(sdata));

   // Clock of 100 ns period.
   always #50 clk = ~clk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Bit length in clocks for the reset divisor and the chosen speed range.
   function automatic logic [7:0] bit_len(input logic [7:0] cw);
      return cw[BIT_HIGH_SPEED] ? RST_DIVISOR[7:0] + 8'h01 : {RST_DIVISOR[5:0], 2'b00} + 8'h01;
   endfunction
   function automatic logic [31:0] ctrl_exp(input logic [7:0] cw, input logic empty);
      return {24'h0, cw[7:2], empty, cw[0]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Write: address and data offered together, each released once taken; a is an index.
   task automatic axw(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s,
                      output logic [1:0] resp);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge clk);
      awaddr <= {a, 2'b00};
      wdata <= {24'h0, v};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk);
         if (!aw && awready === 1'b1) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready === 1'b1) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
      @(posedge clk);
      araddr <= {a, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      logic [1:0] rs;
      axw(a, v, 4'h1, rs);
      chk("bresp", 32'(rs), 32'(RESP_OKAY));
      repeat (2) @(posedge clk);
   endtask
   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
      logic [31:0] v;
      logic [1:0]  rs;
      axr(a, v, rs);
      chk(nm, v, e);
   endtask
   // Program the control word and tell the far receiver what framing to expect.
   task automatic setc(input logic [7:0] cw);
      wr(OFF_TX_CONTROL_STATUS, cw);
      nine <= cw[BIT_NINE_SELECT];
      blen <= bit_len(cw);
      f0 = frames;
   endtask
   task automatic send(input logic [7:0] cw, input logic [7:0] v);
      setc(cw);
      wr(OFF_TX_DATA, v);
      rd_chk("busy", OFF_TX_CONTROL_STATUS, ctrl_exp(cw, 1'b0));
      while (frames == f0) @(posedge clk);
      chk("frame", {22'h0, rx_err, rx_data}, {23'h0, cw[6] & cw[0], v});
      repeat (2 * bit_len(cw)) @(posedge clk);
      rd_chk("empty", OFF_TX_CONTROL_STATUS, ctrl_exp(cw, 1'b1));
   endtask
   task automatic test_done();
      $display("Compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Watchdog sized well past the longest run of the sequence below.
   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      test_done();
   end

   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      rd_chk("ctrl_rst", OFF_TX_CONTROL_STATUS, {24'h0, RST_TX_CONTROL});
      chk("pin_rst", {30'h0, tx_oe, tx_out}, 32'h1);
      rd_chk("div_rst", OFF_BAUD_DIV_LOW, {24'h0, RST_DIVISOR[7:0]});
      axr(12'h004, d, r);
      chk("unmapped_rd", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
      axw(12'h008, 8'hff, 4'h1, r);
      chk("unmapped_wr", 32'(r), 32'(RESP_SLVERR));
      axw(OFF_TX_CONTROL_STATUS, 8'hff, 4'h0, r);
      rd_chk("no_strobe", OFF_TX_CONTROL_STATUS, {24'h0, RST_TX_CONTROL});
      // Corner bytes first, then random framing, ninth bit and data.
      send(8'h24, 8'h00);
      send(8'h65, 8'hff);
      send(8'h64, 8'h81);
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         c = 8'h24 | {1'b0, seed[8], 4'h0, seed[10], seed[9]};
         send(c, seed[7:0]);
      end
      seed = lfsr(seed);
      send(8'h20, seed[7:0]);
      // Break replaces the pending word and the break bit clears itself.
      setc(8'h2c);
      wr(OFF_TX_DATA, 8'h55);
      while (frames == f0) @(posedge clk);
      chk("break", {22'h0, rx_err, rx_data}, 32'h200);
      n = 0;
      do begin
         axr(OFF_TX_CONTROL_STATUS, d, r);
         n++;
      end while (d[BIT_BREAK] && n < 100);
      // The empty bit follows the break clear by a cycle, so read once more.
      axr(OFF_TX_CONTROL_STATUS, d, r);
      chk("break_clr", d, ctrl_exp(8'h24, 1'b1));
      // Pin directions in each mode, and receive enables overriding transmit.
      wr(OFF_TX_CONTROL_STATUS, 8'ha4);
      chk("async_ck", 32'(ck_oe), 32'h0);
      wr(OFF_TX_CONTROL_STATUS, 8'h04);
      chk("tx_off", 32'(tx_oe), 32'h0);
      wr(OFF_TX_CONTROL_STATUS, 8'hb0);
      chk("master", {30'h0, ck_oe, tx_oe}, 32'h3);
      wr(OFF_TX_CONTROL_STATUS, 8'h30);
      chk("slave", 32'(ck_oe), 32'h0);
      wr(OFF_RX_CONTROL_STATUS, 8'h20);
      chk("single_rx", 32'(tx_oe), 32'h0);
      wr(OFF_RX_CONTROL_STATUS, 8'h10);
      chk("cont_rx", 32'(tx_oe), 32'h0);
      wr(OFF_RX_CONTROL_STATUS, 8'h00);
      chk("rx_off", 32'(tx_oe), 32'h1);
      // Synchronous frames: first on the master clock, then on an external clock.
      seed = lfsr(seed);
      wr(OFF_TX_CONTROL_STATUS, 8'hb0);
      wr(OFF_TX_DATA, seed[7:0]);
      repeat (200) @(posedge clk);
      chk("sync_master", {24'h0, sdata[8:1]}, {24'h0, seed[7:0]});
      wr(OFF_TX_CONTROL_STATUS, 8'h30);
      wr(OFF_TX_DATA, ~seed[7:0]);
      repeat (8) begin
         ck_in <= 1'b1;
         repeat (3) @(posedge clk);
         ck_in <= 1'b0;
         repeat (3) @(posedge clk);
      end
      chk("sync_slave", {24'h0, sdata[8:1]}, {24'h0, ~seed[7:0]});
      test_done();
   end
endmodule

// ---- sim/stc_remote_rx.sv ----
// Remote serial receiver model that samples frames off the transmit pin.
`timescale 1ns/100ps
module stc_remote_rx (
   input  wire logic       clk,
   input  wire logic       line,
   input  wire logic       nine,
   input  wire logic [7:0] bit_len,
   input  wire logic       sck,
   output logic [8:0]      data,
   output logic            frame_err,
   output logic [15:0]     frames,
   output logic [8:0]      sync_data
);
   logic [8:0] sh;
   logic       ck_d = 1'b0;
   initial begin
      data = 9'h000;
      sync_data = 9'h000;
      frame_err = 1'b0;
      frames = 16'h0000;
   end
   // Bits are taken at their centres, timed from the falling start edge.
   // A glitch shorter than half a bit is dropped, as a real receiver would.
   always begin
      @(negedge line);
      repeat (bit_len / 2) @(posedge clk);
      if (line === 1'b0) begin
         sh = 9'h000;
         for (int i = 0; i < 9; i++) begin
            if (i < 8 || nine) begin
               repeat (bit_len) @(posedge clk);
               sh[i] = line;
            end
         end
         repeat (bit_len) @(posedge clk);
         frame_err = (line !== 1'b1);
         data = sh;
         frames = frames + 16'h0001;
      end
   end
   // Synchronous frames: one bit is taken at each rising edge of the serial clock.
   always @(posedge clk) begin
      ck_d <= sck;
      if (sck === 1'b1 && ck_d === 1'b0) sync_data <= {line, sync_data[8:1]};
   end
endmodule
